// file: verilog/rmp_mode_arbiter.sv
// operating-mode priority arbiter of the room temperature controller
// Overview of operation
// - forced 03 night, 04 frost protection
// - forced 01 comfort, 02 standby; 00 none
// - 1-byte change-over sets mode at once
// - refresh, expose and send status on change
// - send current mode after device reset
// - presence object follows comfort extension
// - button or presence starts extension
// - extension ends on timeout, press, zero
// - zero length: no extension, mode kept
// - standby presence switches to held comfort
// - button presence cleared on mode change, reset
// - motion forces comfort below window, forced
// - motion release restores tracked base mode
// - open window forces frost protection
// - closed window restores tracked base mode
// - window delay 1..255 minutes, 0 immediate
// - window in heating, cooling; cleared reset
// - minute temperature drop triggers frost
// - auto frost timed, restores, no retrigger
// - byte mode kept, bit mode discarded
// - forced object interrupts auto frost
// - auto frost only heating below setpoint
// - configuration picks window or auto frost
`timescale 1ns/100ps
module rmp_mode_arbiter #(
    parameter longint unsigned TICK_CYCLES = rmp_pkg::MINUTE_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        dev_reset_in,
    input  wire logic [1:0]  cfg_presence_mode_in,
    input  wire logic        cfg_prot_src_in,
    input  wire logic [7:0]  cfg_ext_len_in,
    input  wire logic [7:0]  cfg_win_delay_in,
    input  wire logic [7:0]  cfg_frost_drop_in,
    input  wire logic [7:0]  cfg_frost_period_in,
    input  wire logic        cfg_co_tx_en_in,
    input  wire logic        cfg_co_rd_en_in,
    input  wire logic        co_byte_wr_in,
    input  wire logic [7:0]  co_byte_in,
    input  wire logic        co_bit_wr_in,
    input  wire logic [3:0]  co_bit_in,
    input  wire logic        forced_wr_in,
    input  wire logic [7:0]  forced_in,
    input  wire logic        pres_wr_in,
    input  wire logic        pres_in,
    input  wire logic        button_in,
    input  wire logic        win_wr_in,
    input  wire logic        win_in,
    input  wire logic [15:0] temp_in,
    input  wire logic [15:0] setpoint_in,
    input  wire logic        heating_in,
    output logic [7:0]       co_value_out,
    output logic             co_readable_out,
    output logic             co_tx_out,
    output logic             presence_obj_out,
    output logic             window_obj_out,
    output logic             window_active_out,
    output logic             ext_active_out,
    output logic             frost_active_out
);
    typedef struct packed {
        logic [7:0]        base;
        logic [7:0]        forced;
        rmp_pkg::rmp_pres_e pres;
        logic [7:0]        ext_cnt;
        logic              motion;
        logic              win_obj;
        logic              win_pend;
        logic              win_act;
        logic [7:0]        win_cnt;
        logic              frost_run;
        logic              frost_pend;
        logic [7:0]        frost_cnt;
        logic [15:0]       prev_temp;
        logic              prev_ok;
        logic [7:0]        eff;
        logic              boot;
        logic              tx;
        logic              rd;
        logic              pres_obj;
        logic              ext;
    } rmp_state_s;

    rmp_state_s q;
    rmp_state_s n;
    logic       tick;
    logic       pres_on;
    logic       pres_off;
    logic [16:0] drop;

    function automatic logic mode_ok(input logic [7:0] m);
        return (m >= rmp_pkg::MODE_COMFORT) && (m <= rmp_pkg::MODE_FROST);
    endfunction
    function automatic logic [7:0] bits_mode(input logic [3:0] b);
        if (b[0]) return rmp_pkg::MODE_COMFORT;
        if (b[1]) return rmp_pkg::MODE_STANDBY;
        if (b[2]) return rmp_pkg::MODE_NIGHT;
        return rmp_pkg::MODE_FROST;
    endfunction
    // countdown step on each minute tick
    function automatic logic [7:0] count_down(input logic [7:0] c,
                                              input logic t);
        return (t && c != 8'h00) ? c - 8'h01 : c;
    endfunction
    // priority: forced, protection, motion, button presence, base
    function automatic logic [7:0] arbitrate(input rmp_state_s s);
        if (mode_ok(s.forced)) return s.forced;
        if (s.win_act || s.frost_run) return rmp_pkg::MODE_FROST;
        if (s.motion) return rmp_pkg::MODE_COMFORT;
        if (s.pres != rmp_pkg::PRES_IDLE) return rmp_pkg::MODE_COMFORT;
        return s.base;
    endfunction

    rmp_minute_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_in   (clk_in),
        .srst_in  (srst_in),
        .tick_out (tick)
    );

    assign drop = 17'($signed({q.prev_temp[15], q.prev_temp})
                  - $signed({temp_in[15], temp_in}));

    always_comb begin
        n = q;
        n.tx = 1'b0;
        n.boot = 1'b0;
        n.rd = cfg_co_rd_en_in;
        pres_on = button_in || (pres_wr_in && pres_in);
        pres_off = button_in || (pres_wr_in && !pres_in);

        if (cfg_presence_mode_in == rmp_pkg::PRES_BUTTON) begin
            n.motion = 1'b0;
            case (q.pres)
                rmp_pkg::PRES_IDLE: begin
                    if (pres_on && q.forced == rmp_pkg::MODE_NONE) begin
                        if (q.eff == rmp_pkg::MODE_STANDBY) begin
                            n.pres = rmp_pkg::PRES_HOLD;
                        end else if ((q.eff == rmp_pkg::MODE_NIGHT ||
                                      q.eff == rmp_pkg::MODE_FROST) &&
                                     !q.win_act &&
                                     cfg_ext_len_in != 8'h00) begin
                            n.pres = rmp_pkg::PRES_EXT;
                            n.ext_cnt = cfg_ext_len_in;
                        end
                    end
                end
                rmp_pkg::PRES_EXT: begin
                    if (pres_off || (tick && q.ext_cnt == 8'h01)) begin
                        n.pres = rmp_pkg::PRES_IDLE;
                    end else begin
                        n.ext_cnt = count_down(q.ext_cnt, tick);
                    end
                end
                rmp_pkg::PRES_HOLD: begin
                    if (pres_off) begin
                        n.pres = rmp_pkg::PRES_IDLE;
                    end
                end
                default: begin
                    n.pres = rmp_pkg::PRES_IDLE;
                end
            endcase
        end else begin
            n.pres = rmp_pkg::PRES_IDLE;
            if (cfg_presence_mode_in == rmp_pkg::PRES_MOTION) begin
                if (pres_wr_in) begin
                    n.motion = pres_in;
                end
            end else begin
                n.motion = 1'b0;
            end
        end

        if (co_byte_wr_in && mode_ok(co_byte_in)) begin
            n.base = co_byte_in;
            n.frost_pend = 1'b0;
            n.pres = rmp_pkg::PRES_IDLE;
        end else if (co_bit_wr_in && co_bit_in != 4'h0) begin
            n.pres = rmp_pkg::PRES_IDLE;
            if (q.frost_run) begin
                n.frost_pend = 1'b1;
            end else begin
                n.base = bits_mode(co_bit_in);
            end
        end

        if (cfg_prot_src_in == rmp_pkg::PROT_WINDOW) begin
            if (win_wr_in) begin
                n.win_obj = win_in;
                if (!win_in) begin
                    n.win_act = 1'b0;
                    n.win_pend = 1'b0;
                    n.win_cnt = 8'h00;
                end else if (!q.win_act && !q.win_pend) begin
                    if (cfg_win_delay_in == 8'h00) begin
                        n.win_act = 1'b1;
                        n.pres = rmp_pkg::PRES_IDLE;
                    end else begin
                        n.win_pend = 1'b1;
                        n.win_cnt = cfg_win_delay_in;
                    end
                end
            end else if (q.win_pend && tick) begin
                if (q.win_cnt == 8'h01) begin
                    n.win_pend = 1'b0;
                    n.win_act = 1'b1;
                    n.pres = rmp_pkg::PRES_IDLE;
                end
                n.win_cnt = count_down(q.win_cnt, tick);
            end
        end else begin
            n.win_act = 1'b0;
            n.win_pend = 1'b0;
        end

        if (tick) begin
            n.prev_temp = temp_in;
            n.prev_ok = 1'b1;
        end
        if (cfg_prot_src_in == rmp_pkg::PROT_AUTO) begin
            if (q.frost_run) begin
                if (tick && q.frost_cnt == 8'h01) begin
                    n.frost_run = 1'b0;
                    if (n.frost_pend) begin
                        n.base = rmp_pkg::MODE_FROST;
                    end
                    n.frost_pend = 1'b0;
                end
                n.frost_cnt = count_down(q.frost_cnt, tick);
            end else if (tick && q.prev_ok && heating_in &&
                         $signed(temp_in) < $signed(setpoint_in) &&
                         $signed(drop) >= $signed({9'h000,
                                                   cfg_frost_drop_in}) &&
                         q.forced == rmp_pkg::MODE_NONE &&
                         cfg_frost_period_in != 8'h00) begin
                n.frost_run = 1'b1;
                n.frost_cnt = cfg_frost_period_in;
                n.frost_pend = 1'b0;
                n.pres = rmp_pkg::PRES_IDLE;
            end
        end else begin
            n.frost_run = 1'b0;
            n.frost_pend = 1'b0;
        end

        if (forced_wr_in) begin
            if (forced_in == rmp_pkg::MODE_NONE) begin
                if (q.forced != rmp_pkg::MODE_NONE) begin
                    n.pres = rmp_pkg::PRES_IDLE;
                end
                n.forced = rmp_pkg::MODE_NONE;
            end else if (mode_ok(forced_in)) begin
                n.forced = forced_in;
                n.pres = rmp_pkg::PRES_IDLE;
                n.frost_run = 1'b0;
                n.frost_pend = 1'b0;
                n.frost_cnt = 8'h00;
            end
        end

        if (dev_reset_in) begin
            n.pres = rmp_pkg::PRES_IDLE;
            n.motion = 1'b0;
            n.win_obj = 1'b0;
            n.win_act = 1'b0;
            n.win_pend = 1'b0;
            n.boot = 1'b1;
        end

        n.eff = arbitrate(n);
        n.pres_obj = (n.pres != rmp_pkg::PRES_IDLE) || n.motion;
        n.ext = (n.pres == rmp_pkg::PRES_EXT);
        n.tx = cfg_co_tx_en_in && ((n.eff != q.eff) || q.boot);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            q <= '0;
            q.base <= rmp_pkg::BASE_RST;
            q.eff <= rmp_pkg::BASE_RST;
        end else begin
            q <= n;
        end
    end

    assign co_value_out = q.eff;
    assign co_readable_out = q.rd;
    assign co_tx_out = q.tx;
    assign presence_obj_out = q.pres_obj;
    assign window_obj_out = q.win_obj;
    assign window_active_out = q.win_act;
    assign ext_active_out = q.ext;
    assign frost_active_out = q.frost_run;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    a_forced_night: assert property (
        q.forced == rmp_pkg::MODE_NIGHT |-> co_value_out == 8'h03)
        else $error("forced night not applied");
    a_forced_comfort: assert property (
        forced_wr_in && forced_in == 8'h01 |=> co_value_out == 8'h01)
        else $error("forced comfort not applied");
    a_byte_track: assert property (
        co_byte_wr_in && mode_ok(co_byte_in) && !dev_reset_in
        |=> q.base == $past(co_byte_in))
        else $error("byte change-over not stored");
    a_tx_on_change: assert property (
        co_value_out != $past(co_value_out) && $past(cfg_co_tx_en_in)
        |-> co_tx_out)
        else $error("mode change not sent");
    a_boot_send: assert property (
        dev_reset_in && cfg_co_tx_en_in ##1 cfg_co_tx_en_in
        |=> co_tx_out)
        else $error("mode not sent after device reset");
    a_ext_zero_len: assert property (
        cfg_presence_mode_in == rmp_pkg::PRES_BUTTON && button_in &&
        q.pres == rmp_pkg::PRES_IDLE && co_value_out == 8'h03 &&
        cfg_ext_len_in == 8'h00 |=> !presence_obj_out ##0 !ext_active_out)
        else $error("extension started with zero length");
    a_motion_comfort: assert property (
        q.motion && q.forced == 8'h00 && !q.win_act && !q.frost_run
        |-> co_value_out == 8'h01 && presence_obj_out)
        else $error("motion presence not comfort");
    a_window_now: assert property (
        cfg_prot_src_in == rmp_pkg::PROT_WINDOW && win_wr_in && win_in &&
        cfg_win_delay_in == 8'h00 && !dev_reset_in && !forced_wr_in &&
        q.forced == 8'h00 |=> co_value_out == 8'h04 && window_active_out)
        else $error("window protection not immediate");
    a_reset_clear: assert property (
        dev_reset_in |=> !presence_obj_out && !window_obj_out &&
        !window_active_out)
        else $error("device reset left presence or window");
    a_forced_stops_frost: assert property (
        q.frost_run && forced_wr_in && forced_in == 8'h03 && !dev_reset_in
        |=> !frost_active_out && co_value_out == 8'h03)
        else $error("forced did not interrupt auto frost");

    c_ext_start: cover property (!ext_active_out ##1 ext_active_out);
    c_window_on: cover property (!window_active_out ##1 window_active_out);
    c_frost_run: cover property (frost_active_out ##1 !frost_active_out);
endmodule

// file: verilog/rmp_pkg.sv
// constants and types shared by the room mode arbiter
package rmp_pkg;
    // mode codes carried by the change-over and forced objects
    localparam logic [7:0] MODE_NONE    = 8'h00;
    localparam logic [7:0] MODE_COMFORT = 8'h01;
    localparam logic [7:0] MODE_STANDBY = 8'h02;
    localparam logic [7:0] MODE_NIGHT   = 8'h03;
    localparam logic [7:0] MODE_FROST   = 8'h04;
    localparam logic [7:0] BASE_RST     = 8'h01;

    // presence detection configuration
    localparam logic [1:0] PRES_OFF    = 2'h0;
    localparam logic [1:0] PRES_BUTTON = 2'h1;
    localparam logic [1:0] PRES_MOTION = 2'h2;

    // source of the higher-priority protection switch-over
    localparam logic PROT_WINDOW = 1'h0;
    localparam logic PROT_AUTO   = 1'h1;

    // minute time base
    localparam longint unsigned MINUTE_S      = 64'd60;
    localparam longint unsigned CLK_HZ        = 64'd250_000_000;
    localparam longint unsigned MINUTE_CYCLES = MINUTE_S * CLK_HZ;
    localparam int              TICK_W        = 34;

    typedef enum logic [1:0] {
        PRES_IDLE,
        PRES_EXT,
        PRES_HOLD
    } rmp_pres_e;
endpackage

// file: verilog/rmp_minute_tick.sv
// one-cycle pulse once per minute
`timescale 1ns/100ps
module rmp_minute_tick #(
    parameter longint unsigned TICK_CYCLES = rmp_pkg::MINUTE_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic srst_in,
    output logic      tick_out
);
    typedef struct packed {
        logic [rmp_pkg::TICK_W-1:0] cnt;
        logic                       tick;
    } rmp_tick_s;

    localparam logic [rmp_pkg::TICK_W-1:0] LAST =
        rmp_pkg::TICK_W'(TICK_CYCLES - 64'd1);

    rmp_tick_s q;
    rmp_tick_s n;

    // free-running divider
    always_comb begin
        n = q;
        n.tick = 1'b0;
        if (q.cnt == LAST) begin
            n.cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign tick_out = q.tick;
endmodule

// file: tb/rmp_bus_peer.sv
// bus-side listener that records change-over status telegrams
`timescale 1ns/100ps
module rmp_bus_peer (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        tx_in,
    input  wire logic [7:0]  value_in,
    output logic      [15:0] count_out,
    output logic      [7:0]  last_out
);
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count_out <= 16'h0000;
            last_out  <= 8'h00;
        end else if (tx_in) begin
            count_out <= count_out + 16'h0001;
            last_out  <= value_in;
        end
    end
endmodule

// file: tb/test_room_mode_priority_arbiter.sv
// testbench of the room mode arbiter
`timescale 1ns/100ps
module test_room_mode_priority_arbiter;
    localparam int TK = 10;
    logic clk_in = 0, srst_in = 1, dev_rst = 0, psrc = 0, tx_en = 1;
    logic co_wr = 0, bit_wr = 0, f_wr = 0, p_wr = 0, p_v = 0;
    logic btn = 0, w_wr = 0, w_v = 0, heat = 1, rd_en = 1;
    logic [1:0]  pmode = 2'h0;
    logic [7:0]  ext_len = 8'h02, wdel = 8'h00, co_v = 8'h00, f_v = 8'h00;
    logic [3:0]  bits = 4'h0;
    logic [15:0] temp = 16'h00c8;
    logic [7:0]  mode, lastv;
    logic [15:0] ntx, n0;
    logic        rd, tx, pobj, wobj, wact, ext, frost;
    int          miscompares = 0, n_tests = 0;

    always #2 clk_in = ~clk_in;

    rmp_mode_arbiter #(.TICK_CYCLES(TK)) dut_u (
        .clk_in(clk_in), .srst_in(srst_in), .dev_reset_in(dev_rst),
        .cfg_presence_mode_in(pmode), .cfg_prot_src_in(psrc),
        .cfg_ext_len_in(ext_len), .cfg_win_delay_in(wdel),
        .cfg_frost_drop_in(8'h05), .cfg_frost_period_in(8'h02),
        .cfg_co_tx_en_in(tx_en), .cfg_co_rd_en_in(rd_en),
        .co_byte_wr_in(co_wr), .co_byte_in(co_v),
        .co_bit_wr_in(bit_wr), .co_bit_in(bits),
        .forced_wr_in(f_wr), .forced_in(f_v),
        .pres_wr_in(p_wr), .pres_in(p_v), .button_in(btn),
        .win_wr_in(w_wr), .win_in(w_v), .temp_in(temp),
        .setpoint_in(16'h0190), .heating_in(heat),
        .co_value_out(mode), .co_readable_out(rd), .co_tx_out(tx),
        .presence_obj_out(pobj), .window_obj_out(wobj),
        .window_active_out(wact), .ext_active_out(ext),
        .frost_active_out(frost));

    rmp_bus_peer peer_u (
        .clk_in(clk_in), .srst_in(srst_in), .tx_in(tx),
        .value_in(mode), .count_out(ntx), .last_out(lastv));

    task automatic cyc(int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chb(string nm, logic e, logic g);
        chk(nm, {7'h00, e}, {7'h00, g});
    endtask

    // one telegram or event, then one idle cycle
    task automatic put(int k, logic [7:0] v);
        case (k)
            0: begin co_wr = 1; co_v = v; end
            1: begin f_wr = 1; f_v = v; end
            2: begin p_wr = 1; p_v = v[0]; end
            3: btn = 1;
            4: begin w_wr = 1; w_v = v[0]; end
            5: begin bit_wr = 1; bits = v[3:0]; end
            default: dev_rst = 1;
        endcase
        cyc(1);
        {co_wr, f_wr, p_wr, btn, w_wr, bit_wr, dev_rst} = 7'h00;
        cyc(1);
    endtask

    task automatic wmode(logic [7:0] e, int n);
        for (int i = 0; i < n && mode !== e; i++) cyc(1);
        chk("mode", e, mode);
    endtask

    task automatic test_done;
        if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_in);
        miscompares++;
        test_done;
    end

    initial begin
        cyc(5);
        srst_in = 0;
        chk("mode", rmp_pkg::BASE_RST, mode);
        chk("flags", 8'h00, {pobj, wobj, wact, ext, frost, tx, rd, 1'b0});
        for (int i = 4; i >= 0; i--) begin
            put(0, 8'(i));
            chk("mode", i == 0 ? rmp_pkg::MODE_COMFORT : 8'(i), mode);
        end
        chk("sent", 8'h04, ntx[7:0]);
        chk("sent value", rmp_pkg::MODE_COMFORT, lastv);
        chb("readable", 1'b1, rd);
        tx_en = 0;
        rd_en = 0;
        put(0, rmp_pkg::MODE_STANDBY);
        chk("sent", 8'h04, ntx[7:0]);
        chb("readable", 1'b0, rd);
        tx_en = 1;
        rd_en = 1;
        for (int i = 1; i <= 4; i++) begin
            put(1, 8'(i));
            put(0, rmp_pkg::MODE_NIGHT);
            chk("forced", 8'(i), mode);
        end
        put(1, rmp_pkg::MODE_NONE);
        chk("mode", rmp_pkg::MODE_NIGHT, mode);
        pmode = rmp_pkg::PRES_BUTTON;
        put(3, 0);
        chk("mode", rmp_pkg::MODE_COMFORT, mode);
        chb("presence", 1'b1, pobj);
        put(3, 0);
        chk("mode", rmp_pkg::MODE_NIGHT, mode);
        chb("presence", 1'b0, pobj);
        put(2, 1);
        chb("extension", 1'b1, ext);
        wmode(rmp_pkg::MODE_NIGHT, 2 * TK + 2);
        chb("presence", 1'b0, pobj);
        ext_len = 8'h00;
        put(3, 0);
        chk("mode", rmp_pkg::MODE_NIGHT, mode);
        chb("extension", 1'b0, ext);
        put(0, rmp_pkg::MODE_STANDBY);
        put(2, 1);
        chk("mode", rmp_pkg::MODE_COMFORT, mode);
        put(0, rmp_pkg::MODE_NIGHT);
        chb("presence", 1'b0, pobj);
        put(0, rmp_pkg::MODE_STANDBY);
        put(3, 0);
        put(1, rmp_pkg::MODE_STANDBY);
        put(1, rmp_pkg::MODE_NONE);
        chb("presence", 1'b0, pobj);
        chk("mode", rmp_pkg::MODE_STANDBY, mode);
        pmode = rmp_pkg::PRES_MOTION;
        ext_len = 8'h02;
        put(2, 1);
        chk("mode", rmp_pkg::MODE_COMFORT, mode);
        put(0, rmp_pkg::MODE_NIGHT);
        chk("mode", rmp_pkg::MODE_COMFORT, mode);
        put(2, 0);
        chk("mode", rmp_pkg::MODE_NIGHT, mode);
        n0 = ntx;
        put(6, 0);
        cyc(1);
        chk("sent", n0[7:0] + 8'h01, ntx[7:0]);
        chk("sent value", rmp_pkg::MODE_NIGHT, lastv);
        put(2, 1);
        put(6, 0);
        chb("presence", 1'b0, pobj);
        chk("mode", rmp_pkg::MODE_NIGHT, mode);
        put(2, 1);
        chk("mode", rmp_pkg::MODE_COMFORT, mode);
        put(2, 0);
        pmode = rmp_pkg::PRES_OFF;
        heat = 0;
        put(4, 1);
        chk("mode", rmp_pkg::MODE_FROST, mode);
        chb("window", 1'b1, wact);
        put(0, rmp_pkg::MODE_STANDBY);
        chk("mode", rmp_pkg::MODE_FROST, mode);
        put(4, 0);
        chk("mode", rmp_pkg::MODE_STANDBY, mode);
        wdel = 8'h02;
        put(4, 1);
        chk("mode", rmp_pkg::MODE_STANDBY, mode);
        wmode(rmp_pkg::MODE_FROST, 2 * TK + 2);
        put(6, 0);
        chk("window", 8'h00, {6'h00, wobj, wact});
        heat = 1;
        psrc = rmp_pkg::PROT_AUTO;
        cyc(TK + 1);
        temp = temp - 16'h0005;
        wmode(rmp_pkg::MODE_FROST, TK + 2);
        chb("auto frost", 1'b1, frost);
        put(5, 8'h01);
        chk("mode", rmp_pkg::MODE_FROST, mode);
        cyc(2 * TK + 2);
        chb("auto frost", 1'b0, frost);
        chk("mode", rmp_pkg::MODE_FROST, mode);
        put(0, rmp_pkg::MODE_STANDBY);
        chk("mode", rmp_pkg::MODE_STANDBY, mode);
        temp = temp - 16'h0005;
        wmode(rmp_pkg::MODE_FROST, TK + 2);
        put(0, rmp_pkg::MODE_NIGHT);
        chk("mode", rmp_pkg::MODE_FROST, mode);
        put(1, rmp_pkg::MODE_STANDBY);
        chk("mode", rmp_pkg::MODE_STANDBY, mode);
        put(1, rmp_pkg::MODE_NONE);
        chk("mode", rmp_pkg::MODE_NIGHT, mode);
        put(4, 1);
        chb("window", 1'b0, wact);
        heat = 0;
        cyc(TK + 1);
        temp = temp - 16'h0005;
        cyc(2 * TK);
        chb("auto frost", 1'b0, frost);
        test_done;
    end
endmodule
